// File: brf_cfg.svh
/*
  Constants for the banked register file and stack pointer block:
  addresses, field positions, reset values and RAM sizes.
  Assumes inclusion by bare name from any design file.
*/
`ifndef BRF_CFG_SVH
`define BRF_CFG_SVH

// ****************************************
// Register addresses (8-bit, bank independent)
// ****************************************
`define BRF_ADDR_BGP 8'hFD
`define BRF_ADDR_SP_HIGH 8'hFE
`define BRF_ADDR_SP_LOW 8'hFF
`define BRF_BI_BASE 8'hF0

// ****************************************
// Field positions and reset values
// ****************************************
`define BRF_GRP_MSB 7
`define BRF_GRP_LSB 4
`define BRF_BANK_MSB 3
`define BRF_BANK_LSB 0
`define BRF_BGP_RESET 8'h00
`define BRF_OPT_STACK16_BIT 3

// ****************************************
// Bank codes and map limits
// ****************************************
`define BRF_BANK_0 4'h0
`define BRF_BANK_1 4'h1
`define BRF_BANK_2 4'h2
`define BRF_BANK_3 4'h3
`define BRF_BANK_D 4'hD
`define BRF_BANK_F 4'hF
`define BRF_PORT_LAST 8'h04
`define BRF_GP_FIRST 8'h10
`define BRF_GP_LAST 8'hEF
`define BRF_RAM_WORDS 1024
`define BRF_RAM_AW 10

`endif

// File: brf_pkg.sv
/*
  Types shared by the register file block.
  Assumes brf_cfg.svh is compiled alongside.
*/
package brf_pkg;

  typedef enum logic [2:0] {
    BRF_OP_NONE,
    BRF_OP_PUSH,
    BRF_OP_POP,
    BRF_OP_CALL,
    BRF_OP_INTR
  } brf_op_t;

  // One register file request from the core
  typedef struct packed {
    logic rd;
    logic wr;
    logic linear;
    logic working;
    logic [11:0] addr;
    logic [7:0] wdata;
  } brf_req_t;

  // One stack request from the core
  typedef struct packed {
    brf_op_t op;
    logic [7:0] data;
    logic [15:0] pc;
    logic [7:0] flags;
  } brf_stk_req_t;

endpackage : brf_pkg

// File: brf_ram.sv
/*
  Register file storage: 1024 bytes, one write and one read port,
  registered read data.
  Assumes one clock; contents are undefined after reset.
*/
`timescale 1ns/1ns
`default_nettype none
`include "brf_cfg.svh"

module brf_ram (
  // Clock
  input wire logic core_clk,
  // Write port
  input wire logic we,
  input wire logic [`BRF_RAM_AW-1:0] waddr,
  input wire logic [7:0] wdata,
  // Read port
  input wire logic [`BRF_RAM_AW-1:0] raddr,
  output logic [7:0] rdata
);

  logic [7:0] mem [0:`BRF_RAM_WORDS-1];

  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule : brf_ram
`default_nettype wire

// File: brf_regfile.sv
/*
  Banked register file addressing and stack pointer for an 8-bit core.
  Holds the bank/group pointer, the stack pointer bytes and the RAM map.
  Assumes the core issues at most one register access or one stack
  operation per cycle and waits for done before the next.
*/
// Notes on behaviour
// RULE1: pointer high nibble picks working group
// RULE2: pointer low nibble picks bank
// RULE3: bank zero reaches normal bank 0
// RULE4: nonzero bank swaps in expanded bank
// RULE5: pointer read/write at FDh, resets zero
// RULE6: option bit picks 8/16-bit stack
// RULE7: high byte is plain data in 8-bit mode
// RULE8: 8-bit stack in bank 0 only
// RULE9: push decrements then writes
// RULE10: pop reads then increments
// RULE11: pointer addresses most recent item
// RULE12: call pushes program counter
// RULE13: interrupt pushes counter and flags
// RULE14: software keeps stack in bounds
// RULE15: low byte read/write at FFh
// RULE16: unused high-byte bits ignored by size
// RULE17: software avoids high byte as loop counter
// RULE18: linear 12-bit map, ports, general RAM
// RULE19: F0h-FFh always reach bank 0
// RULE20: banks D/F reach bank 0 at 10h-EFh
// RULE21: 16-bit stack address bank/group/register
// RULE22: stack width from option bit 3
// RULE23: 16-bit pointer carries across bytes
// RULE24: pointer and access finish together
`timescale 1ns/1ns
`default_nettype none
`include "brf_cfg.svh"

module brf_regfile #(
  parameter bit RAM_1K = 1'b1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Option byte from flash
  input wire logic [7:0] second_option_byte,
  // Register access from the core
  input wire brf_pkg::brf_req_t req,
  output logic [7:0] rdata,
  output logic rvalid,
  // Stack operations from the core
  input wire brf_pkg::brf_stk_req_t stk,
  output logic [7:0] stk_rdata,
  output logic stk_done,
  // State for the core
  output logic [7:0] bank_group_pointer,
  output logic [7:0] stack_ptr_high_or_scratch,
  output logic [7:0] stack_ptr_low,
  output logic stack16
);

  // ****************************************
  // Stack sequencer
  // ****************************************
  typedef enum {S_IDLE, S_PUSH, S_POP, S_POPW} brf_st_t;
  brf_st_t state;
  brf_st_t next_state;
  logic [2:0] pend;
  logic [2:0] next_pend;
  logic [7:0] qbyte [0:3];
  logic [7:0] next_qbyte [0:3];
  logic [7:0] next_bgp;
  logic [7:0] next_sp_high;
  logic [7:0] next_sp_low;
  logic next_stack16;
  logic next_rvalid;
  logic next_stk_done;
  logic [7:0] next_stk_rdata;
  logic rd_pend;
  logic next_rd_pend;
  logic [1:0] rsrc;
  logic [1:0] next_rsrc;
  logic [7:0] next_rdata;
  logic opt_seen;
  logic next_opt_seen;
  logic ram_we;
  logic [`BRF_RAM_AW-1:0] ram_waddr;
  logic [7:0] ram_wdata;
  logic [`BRF_RAM_AW-1:0] ram_raddr;
  logic [7:0] ram_rdata;
  logic [`BRF_RAM_AW-1:0] acc_addr;
  logic acc_ok;
  logic [7:0] a8;
  logic [3:0] bank;
  logic [15:0] sp_dec;
  logic [15:0] sp_inc;
  logic [`BRF_RAM_AW-1:0] sp_addr;
  logic [`BRF_RAM_AW-1:0] sp_dec_addr;

  brf_ram u_ram (
    .core_clk(core_clk),
    .we(ram_we),
    .waddr(ram_waddr),
    .wdata(ram_wdata),
    .raddr(ram_raddr),
    .rdata(ram_rdata)
  );

  // ****************************************
  // Address map
  // ****************************************
  // Map a stack pointer value to a RAM location
  function automatic logic [`BRF_RAM_AW-1:0] sp_map(input logic s16, input logic [15:0] sp);
    logic [1:0] hb;
    hb = RAM_1K ? sp[9:8] : {1'b0, sp[8]};
    // RULE16: size-masked high bits
    // RULE21: bank from high byte, group/reg low
    // RULE8: 8-bit stack stays in bank 0
    if (s16) begin
      sp_map = {hb, sp[7:0]};
    end else begin
      sp_map = {2'b00, sp[7:0]};
    end
  endfunction : sp_map

  always_comb begin
    bank = bank_group_pointer[`BRF_BANK_MSB:`BRF_BANK_LSB];
    // RULE1: working operand joins group nibble
    a8 = req.working ? {bank_group_pointer[`BRF_GRP_MSB:`BRF_GRP_LSB], req.addr[3:0]}
                     : req.addr[7:0];
    acc_ok = 1'b1;
    acc_addr = '0;
    if (req.linear) begin
      // RULE18: linear 12-bit addressing
      acc_ok = (req.addr[11:10] == 2'b00);
      acc_addr = req.addr[`BRF_RAM_AW-1:0];
    end else if (a8 >= `BRF_BI_BASE) begin
      // RULE19: bank independent top block
      acc_addr = {2'b00, a8};
    end else if (bank == `BRF_BANK_0) begin
      // RULE3: plain bank 0
      acc_addr = {2'b00, a8};
    end else if (bank == `BRF_BANK_D || bank == `BRF_BANK_F) begin
      // RULE20: D/F share bank 0 general RAM
      // RULE4: low sixteen go to the expanded bank, not in this store
      acc_ok = (a8 >= `BRF_GP_FIRST);
      acc_addr = {2'b00, a8};
    end else if (bank <= `BRF_BANK_3) begin
      // RULE2: implemented RAM banks 1 to 3
      acc_addr = {bank[1:0], a8};
    end else begin
      acc_ok = 1'b0;
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_state = state;
    next_pend = pend;
    for (int i = 0; i < 4; i++) begin
      next_qbyte[i] = qbyte[i];
    end
    next_bgp = bank_group_pointer;
    next_sp_high = stack_ptr_high_or_scratch;
    next_sp_low = stack_ptr_low;
    next_stack16 = stack16;
    next_opt_seen = 1'b1;
    next_rvalid = 1'b0;
    next_stk_done = 1'b0;
    next_stk_rdata = stk_rdata;
    next_rd_pend = 1'b0;
    next_rsrc = rsrc;
    next_rdata = rdata;
    ram_we = 1'b0;
    ram_waddr = acc_addr;
    ram_wdata = req.wdata;
    ram_raddr = acc_addr;
    // RULE23: combined counter when 16-bit
    sp_dec = stack16 ? ({stack_ptr_high_or_scratch, stack_ptr_low} - 16'h0001)
                     : {stack_ptr_high_or_scratch, stack_ptr_low - 8'h01};
    sp_inc = stack16 ? ({stack_ptr_high_or_scratch, stack_ptr_low} + 16'h0001)
                     : {stack_ptr_high_or_scratch, stack_ptr_low + 8'h01};
    sp_addr = sp_map(stack16, {stack_ptr_high_or_scratch, stack_ptr_low});
    sp_dec_addr = sp_map(stack16, sp_dec);
    // Strap the width once, after reset release
    if (!opt_seen) begin
      // RULE22: option bit 3
      // RULE6: one or two byte pointer
      next_stack16 = ~second_option_byte[`BRF_OPT_STACK16_BIT];
    end
    if (rd_pend) begin
      next_rvalid = 1'b1;
      case (rsrc)
        2'd1: next_rdata = bank_group_pointer;
        2'd2: next_rdata = stack_ptr_high_or_scratch;
        2'd3: next_rdata = stack_ptr_low;
        default: next_rdata = ram_rdata;
      endcase
    end
    case (state)
      S_IDLE: begin
        if (stk.op == brf_pkg::BRF_OP_PUSH) begin
          next_qbyte[0] = stk.data;
          next_pend = 3'd1;
          next_state = S_PUSH;
        end else if (stk.op == brf_pkg::BRF_OP_CALL) begin
          // RULE12: save program counter, low byte first
          next_qbyte[0] = stk.pc[7:0];
          next_qbyte[1] = stk.pc[15:8];
          next_pend = 3'd2;
          next_state = S_PUSH;
        end else if (stk.op == brf_pkg::BRF_OP_INTR) begin
          // RULE13: save counter then flags
          next_qbyte[0] = stk.pc[7:0];
          next_qbyte[1] = stk.pc[15:8];
          next_qbyte[2] = stk.flags;
          next_pend = 3'd3;
          next_state = S_PUSH;
        end else if (stk.op == brf_pkg::BRF_OP_POP) begin
          next_state = S_POP;
        end else if (req.wr && acc_ok) begin
          // RULE5: pointer write
          // RULE15: low byte write
          // RULE7: high byte is storage in 8-bit mode
          if (!req.linear || req.addr[11:8] == 4'h0) begin
            if (a8 == `BRF_ADDR_BGP) begin
              next_bgp = req.wdata;
            end else if (a8 == `BRF_ADDR_SP_HIGH) begin
              next_sp_high = req.wdata;
            end else if (a8 == `BRF_ADDR_SP_LOW) begin
              next_sp_low = req.wdata;
            end else begin
              ram_we = 1'b1;
            end
          end else begin
            ram_we = 1'b1;
          end
          next_rvalid = 1'b1;
        end else if (req.rd) begin
          next_rd_pend = 1'b1;
          next_rsrc = 2'd0;
          if (acc_ok && (!req.linear || req.addr[11:8] == 4'h0)) begin
            if (a8 == `BRF_ADDR_BGP) begin
              next_rsrc = 2'd1;
            end else if (a8 == `BRF_ADDR_SP_HIGH) begin
              next_rsrc = 2'd2;
            end else if (a8 == `BRF_ADDR_SP_LOW) begin
              next_rsrc = 2'd3;
            end
          end
        end else if (req.wr) begin
          next_rvalid = 1'b1;
        end
      end
      S_PUSH: begin
        // RULE9: decrement, then write new top
        // RULE11: pointer left on newest byte
        ram_we = 1'b1;
        ram_waddr = sp_dec_addr;
        ram_wdata = qbyte[0];
        next_sp_high = sp_dec[15:8];
        next_sp_low = sp_dec[7:0];
        for (int i = 0; i < 3; i++) begin
          next_qbyte[i] = qbyte[i + 1];
        end
        next_pend = pend - 3'd1;
        if (pend == 3'd1) begin
          // RULE24: done with pointer already updated
          next_stk_done = 1'b1;
          next_state = S_IDLE;
        end
      end
      S_POP: begin
        // RULE10: read current top first
        ram_raddr = sp_addr;
        next_state = S_POPW;
      end
      S_POPW: begin
        // RULE10: increment after the read
        next_stk_rdata = ram_rdata;
        next_sp_high = sp_inc[15:8];
        next_sp_low = sp_inc[7:0];
        // RULE24: done with pointer already updated
        next_stk_done = 1'b1;
        next_state = S_IDLE;
      end
      default: next_state = S_IDLE;
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  // Stack bytes have no reset; software loads them before use
  always_ff @(posedge core_clk) begin
    stack_ptr_high_or_scratch <= next_sp_high;
    stack_ptr_low <= next_sp_low;
    stk_rdata <= next_stk_rdata;
    rdata <= next_rdata;
    rsrc <= next_rsrc;
    for (int i = 0; i < 4; i++) begin
      qbyte[i] <= next_qbyte[i];
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= S_IDLE;
      pend <= 3'd0;
      // RULE5: pointer resets to zero
      bank_group_pointer <= `BRF_BGP_RESET;
      stack16 <= 1'b0;
      opt_seen <= 1'b0;
      rvalid <= 1'b0;
      stk_done <= 1'b0;
      rd_pend <= 1'b0;
    end else begin
      state <= next_state;
      pend <= next_pend;
      bank_group_pointer <= next_bgp;
      stack16 <= next_stack16;
      opt_seen <= next_opt_seen;
      rvalid <= next_rvalid;
      stk_done <= next_stk_done;
      rd_pend <= next_rd_pend;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  // Pop runs idle, read, capture: done and the increment land three samples on
  sequence s_pop_req;
    state == S_IDLE && stk.op == brf_pkg::BRF_OP_POP;
  endsequence
  sequence s_pop_end;
    ##3 stk_done;
  endsequence
  a_pop_done_time: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE10
    s_pop_req |-> s_pop_end)
    else $error("pop not finished in three cycles");
  a_pop_inc_low: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE10
    s_pop_req |-> ##3 stack_ptr_low == $past(stack_ptr_low, 3) + 8'h01)
    else $error("pop did not increment pointer");
  a_push_dec_low: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE9
    state == S_PUSH |=> stack_ptr_low == $past(stack_ptr_low) - 8'h01)
    else $error("push did not decrement pointer");
  a_call_two_bytes: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE12
    state == S_IDLE && stk.op == brf_pkg::BRF_OP_CALL |=> (state == S_PUSH) [*2] ##1 stk_done)
    else $error("call did not push two bytes");
  a_intr_three_bytes: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE13
    state == S_IDLE && stk.op == brf_pkg::BRF_OP_INTR |=> (state == S_PUSH) [*3] ##1 stk_done)
    else $error("interrupt did not push three bytes");
  a_high_hold_8bit: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE7
    !stack16 && state == S_PUSH |=> $stable(stack_ptr_high_or_scratch))
    else $error("high byte moved in 8-bit mode");
  a_ptr_write: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE5
    state == S_IDLE && stk.op == brf_pkg::BRF_OP_NONE && req.wr && !req.working
    && !req.linear && req.addr[7:0] == `BRF_ADDR_BGP |=> bank_group_pointer == $past(req.wdata))
    else $error("pointer write lost");
  a_stack_bank0: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE8
    !stack16 && state == S_PUSH |-> ram_waddr[`BRF_RAM_AW-1:8] == 2'b00)
    else $error("8-bit stack left bank 0");
  a_wr_ack: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE24
    state == S_IDLE && stk.op == brf_pkg::BRF_OP_NONE && req.wr |=> rvalid)
    else $error("write not acknowledged");

endmodule : brf_regfile
`default_nettype wire

// File: brf_core_model.sv
/*
  Model of the core side: issues register accesses and stack operations
  one at a time and waits for the answer under a bounded count.
  Assumes the block answers with rvalid or stk_done as registered pulses.
*/
`timescale 1ns/1ns
`default_nettype none

module brf_core_model (
  // Clock
  input wire logic core_clk,
  // Requests to the block
  output var brf_pkg::brf_req_t req,
  output var brf_pkg::brf_stk_req_t stk,
  // Answers from the block
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire logic [7:0] stk_rdata,
  input wire logic stk_done
);
  initial begin
    req = '0;
    stk.op = brf_pkg::BRF_OP_NONE;
    stk.data = 8'h00;
    stk.pc = 16'h0000;
    stk.flags = 8'h00;
  end

  // ****************************************
  // Register access
  // ****************************************
  task automatic reg_op(input logic wr, input logic lin, input logic wk,
      input logic [11:0] addr, input logic [7:0] wd, output logic [7:0] d, output int lat);
    lat = 1;
    @(posedge core_clk);
    req <= '{rd: !wr, wr: wr, linear: lin, working: wk, addr: addr, wdata: wd};
    @(posedge core_clk);
    // Stale data is inverted so a late sample cannot match by luck
    req.rd <= 1'b0;
    req.wr <= 1'b0;
    req.wdata <= ~wd;
    #1;
    while (rvalid !== 1'b1 && lat < 16) begin
      @(posedge core_clk);
      #1;
      lat++;
    end
    d = rdata;
  endtask : reg_op

  // ****************************************
  // Stack operation
  // ****************************************
  // stays in bounds: callers never push or pop past the ends
  // no loop counter: the high byte is only loaded and read here
  task automatic stk_op(input brf_pkg::brf_op_t op, input logic [7:0] d,
      input logic [15:0] pc, input logic [7:0] fl, output int lat);
    lat = 1;
    @(posedge core_clk);
    stk.op <= op;
    stk.data <= d;
    stk.pc <= pc;
    stk.flags <= fl;
    @(posedge core_clk);
    stk.op <= brf_pkg::BRF_OP_NONE;
    stk.data <= ~d;
    stk.pc <= ~pc;
    stk.flags <= ~fl;
    #1;
    while (stk_done !== 1'b1 && lat < 16) begin
      @(posedge core_clk);
      #1;
      lat++;
    end
  endtask : stk_op
endmodule : brf_core_model

`default_nettype wire

// File: banked_register_file_stack_pointer_test.sv
/*
  Self-checking bench for the banked register file and stack pointer.
  Assumes brf_pkg, brf_ram, brf_regfile and brf_core_model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none

module banked_register_file_stack_pointer_test;
  typedef struct packed {
    logic wr;
    logic lin;
    logic wk;
    logic [11:0] addr;
    logic [7:0] data;
  } brf_row_t;

  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] second_option_byte = 8'hFF;
  brf_pkg::brf_req_t req;
  brf_pkg::brf_stk_req_t stk;
  logic [7:0] rdata, stk_rdata, bank_group_pointer, stack_ptr_high_or_scratch, stack_ptr_low;
  logic rvalid, stk_done, stack16;
  int err_total = 0;
  int samples_checked = 0;
  int cycles = 0;

  // Sequence of accesses; reads carry the expected byte
  brf_row_t rows [17] = '{
    {3'b100, 12'h0FD, 8'h00}, {3'b100, 12'h020, 8'h11}, {3'b010, 12'h020, 8'h11},
    {3'b100, 12'h0FD, 8'h01}, {3'b100, 12'h005, 8'h22}, {3'b010, 12'h105, 8'h22},
    {3'b100, 12'h0FE, 8'h33}, {3'b010, 12'h0FE, 8'h33},
    {3'b100, 12'h0FD, 8'h0D}, {3'b100, 12'h030, 8'h44}, {3'b010, 12'h030, 8'h44},
    {3'b100, 12'h0FD, 8'h73}, {3'b101, 12'h005, 8'h55}, {3'b010, 12'h375, 8'h55},
    {3'b000, 12'h0FD, 8'h73}, {3'b110, 12'h0FF, 8'h80}, {3'b000, 12'h0FF, 8'h80}
  };

  initial begin
    forever #50 core_clk = ~core_clk;
  end

  brf_regfile #(.RAM_1K(1'b1)) dut_u (
    .core_clk(core_clk), .rst_b(rst_b), .second_option_byte(second_option_byte),
    .req(req), .rdata(rdata), .rvalid(rvalid), .stk(stk), .stk_rdata(stk_rdata),
    .stk_done(stk_done), .bank_group_pointer(bank_group_pointer),
    .stack_ptr_high_or_scratch(stack_ptr_high_or_scratch),
    .stack_ptr_low(stack_ptr_low), .stack16(stack16)
  );

  brf_core_model core_u (
    .core_clk(core_clk), .req(req), .stk(stk), .rdata(rdata), .rvalid(rvalid),
    .stk_rdata(stk_rdata), .stk_done(stk_done)
  );

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask : check8

  task automatic acc(input brf_row_t r);
    logic [7:0] d;
    int lat;
    core_u.reg_op(r.wr, r.lin, r.wk, r.addr, r.data, d, lat);
    check8(8'(lat), r.wr ? 8'h01 : 8'h02, "access latency");
    if (!r.wr) begin
      check8(d, r.data, "read data");
    end
  endtask : acc

  task automatic so(input brf_pkg::brf_op_t op, input logic [7:0] d, input logic [15:0] pc,
      input logic [7:0] fl, input logic [7:0] want);
    int lat;
    core_u.stk_op(op, d, pc, fl, lat);
    check8(8'(lat), want, "stack latency");
  endtask : so

  task automatic do_reset(input logic [7:0] opt);
    @(posedge core_clk);
    rst_b <= 1'b0;
    second_option_byte <= opt;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
  endtask : do_reset

  // Hang guard: the run needs under a thousand cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_total++;
      give_verdict();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    do_reset(8'hFF);
    check8(bank_group_pointer, 8'h00, "pointer reset");
    check8({7'h00, stack16}, 8'h00, "8-bit mode");
    foreach (rows[i]) acc(rows[i]);
    $display("test map done");
    // Pointer selects bank 3; 8-bit stack must still land in bank 0
    so(brf_pkg::BRF_OP_PUSH, 8'h5A, 16'h0000, 8'h00, 8'h02);
    check8(stack_ptr_low, 8'h7F, "push pointer");
    acc({3'b010, 12'h07F, 8'h5A});
    so(brf_pkg::BRF_OP_CALL, 8'h00, 16'h1234, 8'h00, 8'h03);
    acc({3'b010, 12'h07E, 8'h34});
    acc({3'b010, 12'h07D, 8'h12});
    so(brf_pkg::BRF_OP_INTR, 8'h00, 16'hABCD, 8'hC5, 8'h04);
    check8(stack_ptr_low, 8'h7A, "intr pointer");
    acc({3'b010, 12'h07C, 8'hCD});
    acc({3'b010, 12'h07B, 8'hAB});
    acc({3'b010, 12'h07A, 8'hC5});
    so(brf_pkg::BRF_OP_POP, 8'h00, 16'h0000, 8'h00, 8'h03);
    check8(stk_rdata, 8'hC5, "pop data");
    check8(stack_ptr_low, 8'h7B, "pop pointer");
    check8(stack_ptr_high_or_scratch, 8'h33, "scratch kept");
    $display("test stack8 done");
    do_reset(8'hF7);
    check8({7'h00, stack16}, 8'h01, "16-bit mode");
    check8(bank_group_pointer, 8'h00, "pointer reset again");
    acc({3'b100, 12'h0FE, 8'hFE});
    acc({3'b100, 12'h0FF, 8'h00});
    // Borrow into the high byte; upper six bits play no part in the address
    so(brf_pkg::BRF_OP_PUSH, 8'h66, 16'h0000, 8'h00, 8'h02);
    check8(stack_ptr_high_or_scratch, 8'hFD, "borrow high");
    check8(stack_ptr_low, 8'hFF, "borrow low");
    acc({3'b010, 12'h1FF, 8'h66});
    so(brf_pkg::BRF_OP_POP, 8'h00, 16'h0000, 8'h00, 8'h03);
    check8(stk_rdata, 8'h66, "pop16 data");
    check8(stack_ptr_high_or_scratch, 8'hFE, "carry high");
    check8(stack_ptr_low, 8'h00, "carry low");
    $display("test stack16 done");
    give_verdict();
  end
endmodule : banked_register_file_stack_pointer_test

`default_nettype wire
